// ### include/bwal_regs.vh
// constants of the breaker wear alarm logger
`ifndef BWAL_REGS_VH
`define BWAL_REGS_VH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define BWAL_OPS_W 18
`define BWAL_CUR_W 16
`define BWAL_TIME_W 32
`define BWAL_CNT_W 16
`define BWAL_LOG_DEPTH 12

// ----------------------------------------------------------------
// event codes
// ----------------------------------------------------------------
`define BWAL_EV_TRIG 3'h0
`define BWAL_EV_A1ON 3'h1
`define BWAL_EV_A1OFF 3'h2
`define BWAL_EV_A2ON 3'h3
`define BWAL_EV_A2OFF 3'h4

// ----------------------------------------------------------------
// status codes
// ----------------------------------------------------------------
`define BWAL_ST_NORMAL 2'h0
`define BWAL_ST_ALARM1 2'h1
`define BWAL_ST_ALARM2 2'h2

// ----------------------------------------------------------------
// event selection bits
// ----------------------------------------------------------------
`define BWAL_SEL_ON 0
`define BWAL_SEL_OFF 1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BWAL_CLK_NS 8
`define BWAL_MS_NS 1000000
`define BWAL_CYC_PER_MS (`BWAL_MS_NS / `BWAL_CLK_NS)

// deduction slope is a fraction with this many fraction bits
`define BWAL_SLOPE_FRAC 8

`endif

// ### src/bwal_breaker_wear_alarm_logger.v
// breaker wear supervision: per-phase wear, two alarm stages, events, log
`timescale 1ns/1ns
`include "bwal_regs.vh"

module bwal_breaker_wear_alarm_logger #(
    parameter OPS_W = `BWAL_OPS_W,
    parameter CUR_W = `BWAL_CUR_W,
    parameter TIME_W = `BWAL_TIME_W,
    parameter CNT_W = `BWAL_CNT_W,
    parameter CYC_PER_MS = `BWAL_CYC_PER_MS
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // breaker open command and phase currents
    input wire openCmd,
    input wire [CUR_W-1:0] curL1,
    input wire [CUR_W-1:0] curL2,
    input wire [CUR_W-1:0] curL3,
    // breaker characteristics
    input wire [OPS_W-1:0] startOps,
    input wire [CUR_W-1:0] curNom,
    input wire [CUR_W-1:0] curMax,
    input wire [OPS_W-1:0] maxDeduct,
    input wire [CUR_W-1:0] deductSlope,
    // alarm settings
    input wire alarm1En,
    input wire [OPS_W-1:0] alarm1Thr,
    input wire alarm2En,
    input wire [OPS_W-1:0] alarm2Thr,
    input wire [1:0] evtSelect,
    // counter controls, one-cycle pulses
    input wire wearReload,
    input wire opCntClr,
    input wire alarm1CntClr,
    input wire alarm2CntClr,
    // time base
    input wire timeLoad,
    input wire [TIME_W-1:0] timeValue,
    // alarm outputs and status
    output reg alarm1Out,
    output reg alarm2Out,
    output wire [1:0] wearStatus,
    output reg [CNT_W-1:0] openOpCnt,
    output reg [CNT_W-1:0] alarm1Cnt,
    output reg [CNT_W-1:0] alarm2Cnt,
    output wire [OPS_W-1:0] remL1,
    output wire [OPS_W-1:0] remL2,
    output wire [OPS_W-1:0] remL3,
    output reg [TIME_W-1:0] timeNow,
    // main event buffer port
    output reg evtValid,
    output reg [2:0] evtCode,
    output reg [TIME_W-1:0] evtTime,
    // log read port
    input wire [3:0] logRdIdx,
    output reg [TIME_W-1:0] logTime,
    output reg [2:0] logCode,
    output reg [3*CUR_W-1:0] logCur,
    output reg [3*OPS_W-1:0] logDed,
    output reg [3*OPS_W-1:0] logRem,
    output reg [3:0] logCount
);

    localparam DEPTH = `BWAL_LOG_DEPTH;
    localparam REC_W = TIME_W + 3 + 3*CUR_W + 6*OPS_W;
    localparam integer MS_LAST_I = CYC_PER_MS - 1;
    localparam [16:0] MS_LAST = MS_LAST_I[16:0];

    // ------------------------------------------------------------
    // wear deduction per phase
    // ------------------------------------------------------------
    function [OPS_W-1:0] wearDeduct;
        input [CUR_W-1:0] cur;
        input [CUR_W-1:0] iNom;
        input [CUR_W-1:0] iMax;
        input [OPS_W-1:0] dMax;
        input [CUR_W-1:0] slope;
        reg [2*CUR_W-1:0] prod;
        reg [2*CUR_W-1:0] lin;
        begin
            prod = (cur - iNom) * slope;
            lin = (prod >> `BWAL_SLOPE_FRAC) + {{(2*CUR_W-1){1'b0}}, 1'b1};
            if (cur <= iNom) begin
                wearDeduct = {{(OPS_W-1){1'b0}}, 1'b1};
            end else if (cur >= iMax ||
                         lin >= {{(2*CUR_W-OPS_W){1'b0}}, dMax}) begin
                wearDeduct = dMax;
            end else begin
                wearDeduct = lin[OPS_W-1:0];
            end
        end
    endfunction

    // ------------------------------------------------------------
    // remaining operations
    // ------------------------------------------------------------
    reg [3*OPS_W-1:0] remReg;
    reg [3*OPS_W-1:0] dedReg;
    reg [3*CUR_W-1:0] trigCurReg;
    wire [3*CUR_W-1:0] curAll = {curL3, curL2, curL1};
    reg [3*OPS_W-1:0] remNext;
    reg [3*OPS_W-1:0] dedNext;
    reg [OPS_W-1:0] d;
    reg [OPS_W-1:0] r;
    integer p;

    always @* begin
        remNext = remReg;
        dedNext = dedReg;
        d = {OPS_W{1'b0}};
        r = {OPS_W{1'b0}};
        for (p = 0; p < 3; p = p + 1) begin
            d = wearDeduct(curAll[p*CUR_W +: CUR_W], curNom, curMax,
                           maxDeduct, deductSlope);
            r = remReg[p*OPS_W +: OPS_W];
            if (wearReload) begin
                remNext[p*OPS_W +: OPS_W] = startOps;
            end else if (openCmd) begin
                dedNext[p*OPS_W +: OPS_W] = d;
                // saturate at zero, a worn breaker stays worn
                remNext[p*OPS_W +: OPS_W] =
                    (r > d) ? r - d : {OPS_W{1'b0}};
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            remReg <= {3*OPS_W{1'b0}};
            dedReg <= {3*OPS_W{1'b0}};
            trigCurReg <= {3*CUR_W{1'b0}};
        end else begin
            remReg <= remNext;
            dedReg <= dedNext;
            if (openCmd) begin
                trigCurReg <= curAll;
            end
        end
    end

    assign remL1 = remReg[OPS_W-1:0];
    assign remL2 = remReg[2*OPS_W-1:OPS_W];
    assign remL3 = remReg[3*OPS_W-1:2*OPS_W];

    // ------------------------------------------------------------
    // alarm stages
    // ------------------------------------------------------------
    wire below1 = (remL1 < alarm1Thr) || (remL2 < alarm1Thr) ||
                  (remL3 < alarm1Thr);
    wire below2 = (remL1 < alarm2Thr) || (remL2 < alarm2Thr) ||
                  (remL3 < alarm2Thr);
    wire alarm1Next = alarm1En && below1;
    wire alarm2Next = alarm2En && below2;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            alarm1Out <= 1'b0;
            alarm2Out <= 1'b0;
        end else begin
            alarm1Out <= alarm1Next;
            alarm2Out <= alarm2Next;
        end
    end

    // second stage is the worse condition and takes precedence
    assign wearStatus = alarm2Out ? `BWAL_ST_ALARM2 :
                        alarm1Out ? `BWAL_ST_ALARM1 :
                        `BWAL_ST_NORMAL;

    // ------------------------------------------------------------
    // cumulative counters
    // ------------------------------------------------------------
    wire a1Rise = alarm1Next && !alarm1Out;
    wire a1Fall = !alarm1Next && alarm1Out;
    wire a2Rise = alarm2Next && !alarm2Out;
    wire a2Fall = !alarm2Next && alarm2Out;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            openOpCnt <= {CNT_W{1'b0}};
            alarm1Cnt <= {CNT_W{1'b0}};
            alarm2Cnt <= {CNT_W{1'b0}};
        end else begin
            // a count arriving with its clear survives as one
            if (openCmd) begin
                openOpCnt <= opCntClr ? {{(CNT_W-1){1'b0}}, 1'b1} :
                             openOpCnt + 1'b1;
            end else if (opCntClr) begin
                openOpCnt <= {CNT_W{1'b0}};
            end
            if (a1Rise) begin
                alarm1Cnt <= alarm1CntClr ? {{(CNT_W-1){1'b0}}, 1'b1} :
                             alarm1Cnt + 1'b1;
            end else if (alarm1CntClr) begin
                alarm1Cnt <= {CNT_W{1'b0}};
            end
            if (a2Rise) begin
                alarm2Cnt <= alarm2CntClr ? {{(CNT_W-1){1'b0}}, 1'b1} :
                             alarm2Cnt + 1'b1;
            end else if (alarm2CntClr) begin
                alarm2Cnt <= {CNT_W{1'b0}};
            end
        end
    end

    // ------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------
    reg [16:0] msDivReg;
    wire msTick = (msDivReg == MS_LAST);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            msDivReg <= 17'h00000;
            timeNow <= {TIME_W{1'b0}};
        end else begin
            msDivReg <= msTick ? 17'h00000 : msDivReg + 17'h00001;
            if (timeLoad) begin
                timeNow <= timeValue;
            end else if (msTick) begin
                timeNow <= timeNow + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // event queue: one event leaves per cycle, lowest code first
    // ------------------------------------------------------------
    reg [4:0] pendReg;
    wire [4:0] pendSet = {a2Fall, a2Rise, a1Fall, a1Rise, openCmd};
    reg [4:0] popMask;
    reg [2:0] popCode;
    reg popOn;
    integer k;

    always @* begin
        popMask = 5'h00;
        popCode = 3'h0;
        for (k = 4; k >= 0; k = k - 1) begin
            if (pendReg[k]) begin
                popMask = 5'h01 << k;
                popCode = k[2:0];
            end
        end
        popOn = (popCode == `BWAL_EV_TRIG) || (popCode == `BWAL_EV_A1ON) ||
                (popCode == `BWAL_EV_A2ON);
    end

    wire popAny = |pendReg;
    wire popSel = popOn ? evtSelect[`BWAL_SEL_ON] :
                  evtSelect[`BWAL_SEL_OFF];

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            pendReg <= 5'h00;
            evtValid <= 1'b0;
            evtCode <= 3'h0;
            evtTime <= {TIME_W{1'b0}};
        end else begin
            // a new event wins over the pop of the same kind
            pendReg <= (pendReg & ~popMask) | pendSet;
            evtValid <= popAny && popSel;
            if (popAny) begin
                evtCode <= popCode;
                evtTime <= timeNow;
            end
        end
    end

    // ------------------------------------------------------------
    // rolling log of on events
    // ------------------------------------------------------------
    reg [REC_W-1:0] logMem [0:DEPTH-1];
    reg [3:0] wrPtrReg;
    wire logWr = popAny && popOn;
    wire [REC_W-1:0] logRec = {timeNow, popCode, trigCurReg, dedReg,
                               remReg};
    wire [4:0] physSum = {1'b0, wrPtrReg} + 5'h0b - {1'b0, logRdIdx};
    wire [4:0] physWrap = (physSum >= 5'h0c) ? physSum - 5'h0c : physSum;
    wire [3:0] physIdx = physWrap[3:0];
    reg [REC_W-1:0] rdRec;

    always @(posedge ref_clk) begin
        if (logWr) begin
            logMem[wrPtrReg] <= logRec;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPtrReg <= 4'h0;
            logCount <= 4'h0;
        end else if (logWr) begin
            // oldest slot is overwritten once twelve are held
            wrPtrReg <= (wrPtrReg == 4'hb) ? 4'h0 : wrPtrReg + 4'h1;
            if (logCount != 4'hc) begin
                logCount <= logCount + 4'h1;
            end
        end
    end

    // index 0 is the newest record; unfilled slots read as zero
    always @* begin
        rdRec = {REC_W{1'b0}};
        if (logRdIdx < logCount) begin
            rdRec = logMem[physIdx];
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            logTime <= {TIME_W{1'b0}};
            logCode <= 3'h0;
            logCur <= {3*CUR_W{1'b0}};
            logDed <= {3*OPS_W{1'b0}};
            logRem <= {3*OPS_W{1'b0}};
        end else begin
            {logTime, logCode, logCur, logDed, logRem} <= rdRec;
        end
    end

endmodule

// ### tb/bwal_props.sv
// concurrent checks on the breaker wear alarm logger ports
`timescale 1ns/1ns
`include "bwal_regs.vh"
module bwal_props #(
    parameter OPS_W = 18,
    parameter TIME_W = 32,
    parameter CNT_W = 16
) (
    // clock, reset, requests
    input wire ref_clk,
    input wire rst_n,
    input wire openCmd,
    input wire wearReload,
    input wire opCntClr,
    input wire timeLoad,
    input wire [TIME_W-1:0] timeValue,
    input wire [OPS_W-1:0] startOps,
    input wire alarm1En,
    input wire alarm2En,
    input wire [OPS_W-1:0] alarm1Thr,
    input wire [OPS_W-1:0] alarm2Thr,
    input wire [1:0] evtSelect,
    // outputs watched
    input wire alarm1Out,
    input wire alarm2Out,
    input wire [1:0] wearStatus,
    input wire [CNT_W-1:0] openOpCnt,
    input wire [OPS_W-1:0] remL1,
    input wire [OPS_W-1:0] remL2,
    input wire [OPS_W-1:0] remL3,
    input wire [TIME_W-1:0] timeNow,
    input wire evtValid,
    input wire [2:0] evtCode,
    input wire [3:0] logCount
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // the past guard keeps the first edge after reset from seeing stale input
    chk_alarm1_eval: assert property (
        $past(rst_n) |-> alarm1Out == $past(alarm1En && (remL1 < alarm1Thr
        || remL2 < alarm1Thr || remL3 < alarm1Thr))) else $error("alarm one");
    chk_alarm2_eval: assert property (
        $past(rst_n) |-> alarm2Out == $past(alarm2En && (remL1 < alarm2Thr
        || remL2 < alarm2Thr || remL3 < alarm2Thr))) else $error("alarm two");
    chk_status_code: assert property (
        wearStatus == (alarm2Out ? `BWAL_ST_ALARM2 : {1'b0, alarm1Out}))
        else $error("status code");
    chk_open_count: assert property (
        openCmd && !opCntClr |=> openOpCnt == $past(openOpCnt) + 1'b1)
        else $error("open count");
    chk_reload_rem: assert property (
        wearReload |=> remL1 == $past(startOps) && remL2 == $past(startOps)
        && remL3 == $past(startOps)) else $error("reload value");
    chk_rem_deduct: assert property (
        openCmd && !wearReload |=> remL1 < $past(remL1) || remL1 == 0)
        else $error("no deduction");
    chk_rem_hold: assert property (
        !openCmd && !wearReload |=> $stable(remL1) && $stable(remL2)
        && $stable(remL3)) else $error("remaining moved");
    chk_trig_event: assert property (
        openCmd ##1 evtSelect[0] |-> ##1 evtValid
        && evtCode == `BWAL_EV_TRIG) else $error("trigger event");
    chk_evt_select: assert property (
        evtValid |-> ((evtCode == `BWAL_EV_A1OFF || evtCode == `BWAL_EV_A2OFF)
        ? $past(evtSelect[1]) : $past(evtSelect[0])))
        else $error("unselected event");
    chk_time_load: assert property (
        timeLoad |=> timeNow == $past(timeValue)) else $error("time load");
    chk_log_bound: assert property (
        logCount <= 4'hc) else $error("log overfull");
endmodule
bind bwal_breaker_wear_alarm_logger bwal_props #(.OPS_W(OPS_W),
    .TIME_W(TIME_W), .CNT_W(CNT_W)) u_props (.ref_clk(ref_clk),
    .rst_n(rst_n), .openCmd(openCmd), .wearReload(wearReload),
    .opCntClr(opCntClr), .timeLoad(timeLoad), .timeValue(timeValue),
    .startOps(startOps), .alarm1En(alarm1En), .alarm2En(alarm2En),
    .alarm1Thr(alarm1Thr), .alarm2Thr(alarm2Thr), .evtSelect(evtSelect),
    .alarm1Out(alarm1Out), .alarm2Out(alarm2Out), .wearStatus(wearStatus),
    .openOpCnt(openOpCnt), .remL1(remL1), .remL2(remL2), .remL3(remL3),
    .timeNow(timeNow), .evtValid(evtValid), .evtCode(evtCode),
    .logCount(logCount));

// ### tb/bwal_breaker_model.sv
// breaker model: open command pulse and phase currents at the trip moment
`timescale 1ns/1ns
module bwal_breaker_model (
    // request from the bench
    input wire fire,
    input wire [15:0] ampsL1,
    input wire [15:0] ampsL2,
    input wire [15:0] ampsL3,
    // toward the logger
    output wire openCmd,
    output wire [15:0] curL1,
    output wire [15:0] curL2,
    output wire [15:0] curL3
);
    // currents only mean something in the open cycle; elsewhere show the
    // inverse so a design sampling the wrong cycle gets caught
    assign openCmd = fire;
    assign curL1 = fire ? ampsL1 : ~ampsL1;
    assign curL2 = fire ? ampsL2 : ~ampsL2;
    assign curL3 = fire ? ampsL3 : ~ampsL3;
endmodule

// ### tb/bwal_tb.sv
// self-checking testbench of the breaker wear alarm logger
`timescale 1ns/1ns
`include "bwal_regs.vh"
module tb;
    reg ref_clk = 1'b0, rst_n = 1'b0, fire = 1'b0;
    reg [15:0] aL1 = 16'h0, aL2 = 16'h0, aL3 = 16'h0;
    reg [15:0] curNom = 16'h64, curMax = 16'h3e8, slope = 16'h100;
    reg [17:0] startOps = 18'h1e, maxDed = 18'h14, thr1 = 18'hf, thr2 = 18'h5;
    reg en1 = 1'b0, en2 = 1'b0, reload = 1'b0, clrOp = 1'b0, clrA1 = 1'b0;
    reg clrA2 = 1'b0, timeLoad = 1'b0;
    reg [1:0] sel = 2'h3;
    reg [31:0] timeValue = 32'h64;
    reg [3:0] rdIdx = 4'h0;
    wire openCmd, a1, a2, evtValid;
    wire [15:0] c1, c2, c3, opCnt, a1Cnt, a2Cnt;
    wire [1:0] status;
    wire [17:0] r1, r2, r3;
    wire [31:0] timeNow, evtTime, logTime;
    wire [2:0] evtCode, logCode;
    wire [47:0] logCur;
    wire [53:0] logDed, logRem;
    wire [3:0] logCount;
    integer n_fail = 0, total_checks = 0, i;
    reg [2:0] evq[$];
    always #4 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (evtValid === 1'b1) evq.push_back(evtCode);
    bwal_breaker_model model (.fire(fire), .ampsL1(aL1), .ampsL2(aL2),
        .ampsL3(aL3), .openCmd(openCmd), .curL1(c1), .curL2(c2), .curL3(c3));
    bwal_breaker_wear_alarm_logger #(.CYC_PER_MS(10)) dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .openCmd(openCmd), .curL1(c1), .curL2(c2), .curL3(c3),
        .startOps(startOps), .curNom(curNom), .curMax(curMax),
        .maxDeduct(maxDed), .deductSlope(slope), .alarm1En(en1),
        .alarm1Thr(thr1), .alarm2En(en2), .alarm2Thr(thr2), .evtSelect(sel),
        .wearReload(reload), .opCntClr(clrOp), .alarm1CntClr(clrA1),
        .alarm2CntClr(clrA2), .timeLoad(timeLoad), .timeValue(timeValue),
        .alarm1Out(a1), .alarm2Out(a2), .wearStatus(status),
        .openOpCnt(opCnt), .alarm1Cnt(a1Cnt), .alarm2Cnt(a2Cnt), .remL1(r1),
        .remL2(r2), .remL3(r3), .timeNow(timeNow), .evtValid(evtValid),
        .evtCode(evtCode), .evtTime(evtTime), .logRdIdx(rdIdx),
        .logTime(logTime), .logCode(logCode), .logCur(logCur),
        .logDed(logDed), .logRem(logRem), .logCount(logCount));
    task tick(input integer n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task check(input [63:0] got, input [63:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %0h want %0h",
                         $time, got, exp);
            end
        end
    endtask
    // one open operation, then time for alarms and events to settle
    task op(input [15:0] x1, input [15:0] x2, input [15:0] x3);
        begin
            {aL1, aL2, aL3, fire} = {x1, x2, x3, 1'b1};
            tick(1);
            {fire, timeLoad} = 2'h0;
            tick(8);
        end
    endtask
    task evchk(input [3:0] n, input [11:0] codes);
        integer k;
        begin
            check(evq.size(), n);
            for (k = 0; k < evq.size() && k < 4; k = k + 1)
                check(evq[k], codes[3*k+:3]);
            evq.delete();
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        tick(16);
        rst_n = 1'b1;
        tick(1);
        check({opCnt, logCount, status}, 22'h0);
        reload = 1'b1;
        tick(1);
        {reload, en1, en2} = 3'h3;
        tick(2);
        check({r3, r2, r1, a1}, {{3{18'h1e}}, 1'b0});
        $display("test reset done");
        op(16'h32, 16'h6e, 16'h3e8);
        check({r3, r2, r1}, {18'ha, 18'h13, 18'h1d});
        check({opCnt, a2, a1}, {16'h1, 2'h1});
        check(status, `BWAL_ST_ALARM1);
        evchk(2, {6'h0, `BWAL_EV_A1ON, `BWAL_EV_TRIG});
        op(16'h32, 16'h32, 16'h3e8);
        check({r3, r2, r1}, {18'h0, 18'h12, 18'h1c});
        check({a2, a1, a2Cnt, a1Cnt}, {2'h3, 32'h10001});
        check(status, `BWAL_ST_ALARM2);
        evchk(2, {6'h0, `BWAL_EV_A2ON, `BWAL_EV_TRIG});
        tick(1);
        check({logCount, logCode}, {4'h4, `BWAL_EV_A2ON});
        check(logRem, {18'h0, 18'h12, 18'h1c});
        check(logCur, {16'h3e8, 32'h320032});
        check(logDed, {18'h14, 36'h40001});
        rdIdx = 4'h3;
        tick(1);
        check(logCode, `BWAL_EV_TRIG);
        $display("test alarms done");
        {clrOp, clrA1, en2} = 3'h6;
        tick(1);
        {clrOp, clrA1} = 2'h0;
        tick(6);
        check({opCnt, a1Cnt, a2Cnt, a2}, {48'h1, 1'b0});
        check(status, `BWAL_ST_ALARM1);
        evchk(1, {9'h0, `BWAL_EV_A2OFF});
        {reload, clrA2} = 2'h3;
        tick(1);
        {reload, clrA2} = 2'h0;
        tick(6);
        check({a2Cnt, a1, logCount}, 21'h4);
        evchk(1, {9'h0, `BWAL_EV_A1OFF});
        $display("test clear done");
        sel = 2'h2;
        op(16'h32, 16'h32, 16'h32);
        evchk(0, 12'h0);
        check(logCount, 4'h5);
        sel = 2'h1;
        for (i = 0; i < 12; i = i + 1) begin
            timeLoad = (i == 0);
            op(16'h32, 16'h32, 16'h32);
            if (i == 0) check(evtTime, 32'h64);
        end
        check({logCount, opCnt, r1}, {4'hc, 16'hd, 18'h11});
        evchk(12, 12'h0);
        rdIdx = 4'hb;
        tick(1);
        check(logCode, `BWAL_EV_TRIG);
        check(logTime, 32'h64);
        $display("test log done");
        final_report;
    end
endmodule
